// *** rtl/cipv_regs.vh ***
// Constants for the interrupt priority and vectoring block.
// Assumes inclusion by bare name from rtl/.
`ifndef CIPV_REGS_VH
`define CIPV_REGS_VH
`define CIPV_NSRC        17
`define CIPV_IDXW        5
`define CIPV_SWI_IDX     5'h00
`define CIPV_NONE_IDX    5'h1F
`define CIPV_VEC_SWI     16'hFFFC
`define CIPV_VEC_TOP     16'hFFFA
`define CIPV_VEC_STEP    16'h0002
`define CIPV_SP_RESET    8'hFF
`define CIPV_CCR_IMASK   3
`define CIPV_CCR_RESET   8'h08
`define CIPV_PC_ONE      16'h0001
`define CIPV_BYTE_ZERO   8'h00
`define CIPV_WORD_ZERO   16'h0000
`define CIPV_STK_BYTES   3'h5
`define CIPV_TMR_ZERO    16'h0000
`endif

// *** rtl/cipv_top.v ***
// Interrupt recognition, priority and vectoring for an 8-bit core.
// Assumes one bus clock; the core hands over its context and an
// instruction boundary strobe, and owns a byte-wide memory port.
`timescale 1ns/10ps
`include "cipv_regs.vh"

// What this block does
// R1: Entry pushes the working registers; return pops them so the program resumes.
// R2: Entry sets the global mask; a latched request is pre-empted only by the software interrupt.
// R3: Pending requests are examined at each instruction end when mask clear.
// R4: Lowest priority number wins; priority 0 is highest.
// R5: A request pending at return completion is taken before the next instruction.
// R6: High index register is never stacked; routines save it themselves.
// R7: After saving context the PC loads from the source vector pair.
// R8: Global mask gates every source except the software interrupt.
// R9: Software interrupt is unmaskable priority 0 at the second-highest vector.
// R10: Software interrupt stacks next address; hardware interrupts stack it minus one.
// R11: Break comparator hit forces a software interrupt.
// R12: Low external pin latches its flag; masked; priority 1.
// R13: PLL lock change sets flag; enabled it requests priority 2.
// R14: Timer 1 rollover after modulo match sets overflow; priority 5.
// R15: Timer 1 channel 0 and 1 events request at priorities 3 and 4.
// R16: Timer 2 rollover after modulo match sets overflow; priority 8.
// R17: Timer 2 channel 0 and 1 events request at priorities 6 and 7.
// R18: SPI receive-full sets on each byte received; priority 9.
// R19: SPI transmit-empty sets on each byte moved to shifter; priority 10.
// R20: Mode fault sets on slave select misuse; error enable requests receive slot.
// R21: SPI overflow sets on unread byte overrun; error enable requests receive slot.
// R22: Serial errors share 11, receive and idle 12, transmit 13.
// R23: Keyboard 14, converter 15, timebase 16 at the lowest vector.
// R24: Each maskable slot drives one pending indicator, shared vectors share one.
// R25: An executing instruction is never aborted; service starts after it.
// R26: Stack PC low, PC high, index low, accumulator, condition codes; reverse on return.
// R27: Vectors are fetched high byte first from the lower address.
module cipv_top (
  // Clock and reset
  input  wire        I_CLK_SYS,
  input  wire        I_RST_N,
  // Core handshake
  input  wire        i_instr_done,
  input  wire        i_software_irq_instr,
  input  wire        i_return_from_irq_instr,
  input  wire        i_break_hit,
  input  wire [15:0] i_next_pc,
  input  wire [7:0]  i_index_low,
  input  wire [7:0]  i_accum,
  input  wire [7:0]  i_ccr,
  input  wire        i_ccr_load,
  // Memory port
  input  wire [7:0]  i_mem_rdata,
  // Source inputs
  input  wire        i_ext_request_pin,
  input  wire        i_ext_request_mask,
  input  wire        i_ext_request_ack,
  input  wire        i_pll_lock,
  input  wire        i_pll_change_enable,
  input  wire        i_pll_change_ack,
  input  wire [1:0]  i_tmr_count_zero,
  input  wire [1:0]  i_tmr_modulo_match,
  input  wire [1:0]  i_timer_overflow_enable,
  input  wire [1:0]  i_timer_overflow_ack,
  input  wire [3:0]  i_tmr_chan_event,
  input  wire [3:0]  i_timer_channel_enable,
  input  wire [3:0]  i_timer_channel_ack,
  input  wire        i_spi_rx_xfer,
  input  wire        i_spi_rx_read,
  input  wire        i_spi_rx_enable,
  input  wire        i_spi_tx_xfer,
  input  wire        i_spi_tx_ack,
  input  wire        i_spi_tx_enable,
  input  wire        i_spi_master,
  input  wire        i_spi_busy,
  input  wire        i_spi_ss,
  input  wire        i_spi_mode_fault_detect_en,
  input  wire        i_spi_error_enable,
  input  wire        i_spi_error_ack,
  input  wire [2:0]  i_sci_req,
  input  wire        i_keypad_req,
  input  wire        i_converter_req,
  input  wire        i_timebase_req,
  // Core outputs
  output reg         o_busy,
  output reg         o_pc_load,
  output reg  [15:0] o_pc,
  output reg  [7:0]  o_ccr,
  output reg  [7:0]  o_index_low,
  output reg  [7:0]  o_accum,
  output reg         o_ctx_restore,
  output reg         o_mem_we,
  output reg         o_mem_re,
  output reg  [15:0] o_mem_addr,
  output reg  [7:0]  o_mem_wdata,
  // Flags and indicators
  output reg  [16:1] o_pending_indicator_n,
  output reg         o_ext_request_flag,
  output reg         o_pll_change_flag,
  output reg  [1:0]  o_timer_overflow_flag,
  output reg  [3:0]  o_timer_channel_flag,
  output reg         o_spi_rx_full_flag,
  output reg         o_spi_tx_empty_flag,
  output reg         o_spi_mode_fault_flag,
  output reg         o_spi_overflow_flag
);

  localparam [6:0] ST_IDLE = 7'h01;
  localparam [6:0] ST_PUSH = 7'h02;
  localparam [6:0] ST_VECH = 7'h04;
  localparam [6:0] ST_VECL = 7'h08;
  localparam [6:0] ST_POP  = 7'h10;
  localparam [6:0] ST_POPW = 7'h20;
  localparam [6:0] ST_DONE = 7'h40;

  reg  [6:0]  state_q;
  reg  [2:0]  cnt_q;
  reg  [7:0]  sp_q;
  reg  [15:0] vec_q;
  reg  [15:0] ret_pc_q;
  reg         pll_lock_q;
  reg         ss_q;
  reg  [1:0]  tmr_armed_q;
  reg         swi_q;
  reg  [`CIPV_NSRC-1:0] req;
  reg  [`CIPV_IDXW-1:0] win;
  integer     k;

  // Lowest index wins
  function [`CIPV_IDXW-1:0] pick;
    input [`CIPV_NSRC-1:0] r;
    integer j;
    begin
      pick = `CIPV_NONE_IDX;
      for (j = `CIPV_NSRC - 1; j >= 0; j = j - 1) begin
        if (r[j]) begin
          pick = j[`CIPV_IDXW-1:0]; // R4
        end
      end
    end
  endfunction

  // Source flags; a set in the same cycle as an ack wins
  always @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      o_ext_request_flag    <= 1'b0;
      o_pll_change_flag     <= 1'b0;
      o_timer_overflow_flag <= 2'b00;
      o_timer_channel_flag  <= 4'h0;
      o_spi_rx_full_flag    <= 1'b0;
      o_spi_tx_empty_flag   <= 1'b0;
      o_spi_mode_fault_flag <= 1'b0;
      o_spi_overflow_flag   <= 1'b0;
      pll_lock_q            <= 1'b0;
      ss_q                  <= 1'b1;
      tmr_armed_q           <= 2'b00;
    end else begin
      pll_lock_q <= i_pll_lock;
      ss_q       <= i_spi_ss;
      o_ext_request_flag <= !i_ext_request_pin |
        (o_ext_request_flag & !i_ext_request_ack); // R12
      o_pll_change_flag <= (i_pll_lock ^ pll_lock_q) |
        (o_pll_change_flag & !i_pll_change_ack); // R13
      for (k = 0; k < 2; k = k + 1) begin
        // Rollover counts only after a modulo match
        if (i_tmr_modulo_match[k]) begin
          tmr_armed_q[k] <= 1'b1;
        end else if (i_tmr_count_zero[k]) begin
          tmr_armed_q[k] <= 1'b0;
        end
        o_timer_overflow_flag[k] <=
          (i_tmr_count_zero[k] & tmr_armed_q[k]) |
          (o_timer_overflow_flag[k] & !i_timer_overflow_ack[k]); // R14 R16
      end
      o_timer_channel_flag <= i_tmr_chan_event |
        (o_timer_channel_flag & ~i_timer_channel_ack); // R15 R17
      o_spi_rx_full_flag <= i_spi_rx_xfer |
        (o_spi_rx_full_flag & !i_spi_rx_read); // R18
      o_spi_tx_empty_flag <= i_spi_tx_xfer |
        (o_spi_tx_empty_flag & !i_spi_tx_ack); // R19
      o_spi_overflow_flag <= (i_spi_rx_xfer & o_spi_rx_full_flag &
        !i_spi_rx_read) |
        (o_spi_overflow_flag & !i_spi_error_ack); // R21
      o_spi_mode_fault_flag <= (i_spi_mode_fault_detect_en &
        ((!i_spi_master & i_spi_busy & i_spi_ss & !ss_q) |
         (i_spi_master & !i_spi_ss))) |
        (o_spi_mode_fault_flag & !i_spi_error_ack); // R20
    end
  end

  // Request vector, index equals priority
  always @* begin
    req     = {`CIPV_NSRC{1'b0}};
    req[0]  = i_software_irq_instr | i_break_hit; // R9 R11
    req[1]  = o_ext_request_flag & !i_ext_request_mask; // R12
    req[2]  = o_pll_change_flag & i_pll_change_enable; // R13
    req[3]  = o_timer_channel_flag[0] & i_timer_channel_enable[0]; // R15
    req[4]  = o_timer_channel_flag[1] & i_timer_channel_enable[1];
    req[5]  = o_timer_overflow_flag[0] & i_timer_overflow_enable[0];
    req[6]  = o_timer_channel_flag[2] & i_timer_channel_enable[2]; // R17
    req[7]  = o_timer_channel_flag[3] & i_timer_channel_enable[3];
    req[8]  = o_timer_overflow_flag[1] & i_timer_overflow_enable[1];
    req[9]  = (o_spi_rx_full_flag & i_spi_rx_enable) |
      ((o_spi_overflow_flag | o_spi_mode_fault_flag) &
       i_spi_error_enable); // R20 R21
    req[10] = o_spi_tx_empty_flag & i_spi_tx_enable; // R19
    req[13:11] = i_sci_req; // R22
    req[14] = i_keypad_req; // R23
    req[15] = i_converter_req;
    req[16] = i_timebase_req;
    // Hardware slots gated by the global mask
    if (o_ccr[`CIPV_CCR_IMASK]) begin
      req[`CIPV_NSRC-1:1] = {(`CIPV_NSRC-1){1'b0}}; // R8
    end
    win = pick(req);
  end

  always @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      o_pending_indicator_n <= 16'h0000;
    end else begin
      o_pending_indicator_n <= {i_timebase_req, i_converter_req,
        i_keypad_req, i_sci_req,
        o_spi_tx_empty_flag & i_spi_tx_enable,
        (o_spi_rx_full_flag & i_spi_rx_enable) |
        ((o_spi_overflow_flag | o_spi_mode_fault_flag) &
         i_spi_error_enable),
        o_timer_overflow_flag[1] & i_timer_overflow_enable[1],
        o_timer_channel_flag[3:2] & i_timer_channel_enable[3:2],
        o_timer_overflow_flag[0] & i_timer_overflow_enable[0],
        o_timer_channel_flag[1:0] & i_timer_channel_enable[1:0],
        o_pll_change_flag & i_pll_change_enable,
        o_ext_request_flag & !i_ext_request_mask}; // R24
    end
  end

  // Entry and return sequencer
  always @(posedge I_CLK_SYS or negedge I_RST_N) begin
    if (!I_RST_N) begin
      state_q       <= ST_IDLE;
      cnt_q         <= 3'h0;
      sp_q          <= `CIPV_SP_RESET;
      vec_q         <= `CIPV_WORD_ZERO;
      ret_pc_q      <= `CIPV_WORD_ZERO;
      swi_q         <= 1'b0;
      o_busy        <= 1'b0;
      o_pc_load     <= 1'b0;
      o_pc          <= `CIPV_WORD_ZERO;
      o_ccr         <= `CIPV_CCR_RESET;
      o_index_low   <= `CIPV_BYTE_ZERO;
      o_accum       <= `CIPV_BYTE_ZERO;
      o_ctx_restore <= 1'b0;
      o_mem_we      <= 1'b0;
      o_mem_re      <= 1'b0;
      o_mem_addr    <= `CIPV_WORD_ZERO;
      o_mem_wdata   <= `CIPV_BYTE_ZERO;
    end else begin
      o_pc_load     <= 1'b0;
      o_ctx_restore <= 1'b0;
      o_mem_we      <= 1'b0;
      o_mem_re      <= 1'b0;
      if (i_ccr_load && state_q == ST_IDLE) begin
        o_ccr <= i_ccr;
      end
      case (state_q)
        ST_IDLE: begin
          // Only at an instruction end, never mid-instruction
          if (i_instr_done && win != `CIPV_NONE_IDX) begin // R3 R25
            o_busy   <= 1'b1;
            swi_q    <= (win == `CIPV_SWI_IDX);
            vec_q    <= (win == `CIPV_SWI_IDX) ? `CIPV_VEC_SWI :
              `CIPV_VEC_TOP - `CIPV_VEC_STEP *
              {11'h000, win - 5'h01}; // R7 R9 R23
            ret_pc_q <= (win == `CIPV_SWI_IDX) ? i_next_pc :
              i_next_pc - `CIPV_PC_ONE; // R10
            o_ccr    <= i_ccr;
            o_index_low <= i_index_low;
            o_accum  <= i_accum;
            cnt_q    <= 3'h0;
            state_q  <= ST_PUSH; // R1
          end else if (i_return_from_irq_instr) begin
            o_busy   <= 1'b1;
            cnt_q    <= 3'h0;
            state_q  <= ST_POP;
          end else begin
            o_busy   <= 1'b0;
          end
        end
        ST_PUSH: begin
          // High index register deliberately left off the stack
          o_mem_we   <= 1'b1; // R6
          o_mem_addr <= {8'h00, sp_q};
          sp_q       <= sp_q - 8'h01;
          cnt_q      <= cnt_q + 3'h1;
          case (cnt_q)
            3'h0: o_mem_wdata <= ret_pc_q[7:0]; // R26
            3'h1: o_mem_wdata <= ret_pc_q[15:8];
            3'h2: o_mem_wdata <= o_index_low;
            3'h3: o_mem_wdata <= o_accum;
            default: o_mem_wdata <= o_ccr;
          endcase
          if (cnt_q == `CIPV_STK_BYTES - 3'h1) begin
            o_ccr[`CIPV_CCR_IMASK] <= 1'b1; // R2
            o_mem_re   <= 1'b1;
            state_q    <= ST_VECH;
          end
        end
        ST_VECH: begin
          o_mem_re   <= 1'b1;
          o_mem_addr <= vec_q; // R27
          cnt_q      <= 3'h0;
          state_q    <= ST_VECL;
        end
        ST_VECL: begin
          cnt_q <= cnt_q + 3'h1;
          if (cnt_q == 3'h0) begin
            o_mem_re   <= 1'b1;
            o_mem_addr <= vec_q + `CIPV_PC_ONE;
          end else if (cnt_q == 3'h1) begin
            o_pc[15:8] <= i_mem_rdata;
          end else begin
            o_pc[7:0]  <= i_mem_rdata;
            o_pc_load  <= 1'b1; // R7
            state_q    <= ST_DONE;
          end
        end
        ST_POP: begin
          // Reverse of the push order
          o_mem_re   <= 1'b1;
          o_mem_addr <= {8'h00, sp_q + 8'h01};
          sp_q       <= sp_q + 8'h01;
          state_q    <= ST_POPW;
        end
        ST_POPW: begin
          if (o_mem_re == 1'b0) begin
            cnt_q <= cnt_q + 3'h1;
            case (cnt_q)
              3'h0: o_ccr <= i_mem_rdata; // R26
              3'h1: o_accum <= i_mem_rdata;
              3'h2: o_index_low <= i_mem_rdata;
              3'h3: o_pc[15:8] <= i_mem_rdata;
              default: o_pc[7:0] <= i_mem_rdata;
            endcase
            if (cnt_q == `CIPV_STK_BYTES - 3'h1) begin
              o_ctx_restore <= 1'b1; // R1
              o_pc_load     <= 1'b1;
              state_q       <= ST_DONE;
            end else begin
              state_q       <= ST_POP;
            end
          end
        end
        default: begin
          // Back to idle; a request still pending is taken at the
          // next boundary before the resumed instruction runs
          o_busy  <= 1'b0; // R5
          swi_q   <= 1'b0;
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

endmodule

// *** sim/cipv_top_checker.sv ***
// Port-level assertions for the interrupt priority and vectoring block.
// Assumes it is bound to cipv_top and sees only its ports.
`timescale 1ns/10ps
module cipv_top_checker (
  // Clock and reset
  input wire        I_CLK_SYS,
  input wire        I_RST_N,
  // Core and sources
  input wire        i_instr_done,
  input wire        i_software_irq_instr,
  input wire        i_return_from_irq_instr,
  input wire        i_break_hit,
  input wire        i_ext_request_pin,
  input wire        i_ext_request_mask,
  input wire        i_pll_lock,
  input wire [1:0]  i_tmr_count_zero,
  input wire [1:0]  i_tmr_modulo_match,
  input wire [3:0]  i_tmr_chan_event,
  input wire        i_spi_rx_xfer,
  input wire        i_spi_rx_read,
  input wire        i_spi_tx_xfer,
  // Outputs
  input wire        o_busy,
  input wire        o_pc_load,
  input wire        o_ctx_restore,
  input wire [7:0]  o_ccr,
  input wire        o_mem_we,
  input wire        o_mem_re,
  input wire [15:0] o_mem_addr,
  input wire        o_ext_request_flag,
  input wire        o_pll_change_flag,
  input wire [1:0]  o_timer_overflow_flag,
  input wire [3:0]  o_timer_channel_flag,
  input wire        o_spi_rx_full_flag,
  input wire        o_spi_tx_empty_flag,
  input wire        o_spi_overflow_flag
);
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RST_N);
  // Idle instruction boundary, and one without a software interrupt
  wire bnd_w = !o_busy && i_instr_done && !i_return_from_irq_instr;
  wire hw_w  = bnd_w && !i_software_irq_instr && !i_break_hit;

  AST_MASKED: assert property (hw_w && o_ccr[3] |=> !o_busy)
    else $error("masked request was taken");
  AST_MASK_SET: assert property ($fell(o_mem_we) |-> o_ccr[3])
    else $error("mask not set after stacking");
  AST_PC_LOAD: assert property ($rose(o_busy) |-> ##[1:24] o_pc_load)
    else $error("no pc load after sequence start");
  AST_SWI_VEC: assert property (bnd_w && i_software_irq_instr
    |-> ##[1:12] (o_mem_re && o_mem_addr == 16'hFFFC))
    else $error("software interrupt vector not fetched");
  AST_BRK_VEC: assert property (bnd_w && i_break_hit
    |-> ##[1:12] (o_mem_re && o_mem_addr == 16'hFFFC))
    else $error("break did not fetch the software vector");
  AST_EXT_VEC: assert property (hw_w && !o_ccr[3] && o_ext_request_flag
    && !i_ext_request_mask |-> ##[1:12] (o_mem_re && o_mem_addr == 16'hFFFA))
    else $error("external request vector not fetched");
  AST_PUSH: assert property (o_mem_we ##1 o_mem_we
    |-> o_mem_addr == $past(o_mem_addr) - 16'h0001)
    else $error("stack pushes not descending");
  AST_VEC_PAIR: assert property (o_mem_re && o_mem_addr[15:8] == 8'hFF
    && !o_mem_addr[0] |=> o_mem_re && o_mem_addr == $past(o_mem_addr) + 16'h0001)
    else $error("vector low byte not fetched next");
  AST_EXT_FLAG: assert property (!i_ext_request_pin |=> o_ext_request_flag)
    else $error("external flag not latched");
  AST_PLL_FLAG: assert property ($changed(i_pll_lock) |=> o_pll_change_flag)
    else $error("lock change flag not set");
  AST_TOF: assert property (i_tmr_modulo_match[0] ##1 i_tmr_count_zero[0]
    |=> o_timer_overflow_flag[0])
    else $error("timer overflow flag not set");
  AST_CHAN: assert property (i_tmr_chan_event[0] |=> o_timer_channel_flag[0])
    else $error("channel flag not set");
  AST_RX_FULL: assert property (i_spi_rx_xfer |=> o_spi_rx_full_flag)
    else $error("receive full flag not set");
  AST_TX_EMPTY: assert property (i_spi_tx_xfer |=> o_spi_tx_empty_flag)
    else $error("transmit empty flag not set");
  AST_OVERFLOW: assert property (i_spi_rx_xfer && o_spi_rx_full_flag
    && !i_spi_rx_read |=> o_spi_overflow_flag)
    else $error("overflow flag not set");

  cover property (o_pc_load && o_ctx_restore);
  cover property (i_instr_done && i_break_hit);
  cover property (o_spi_overflow_flag);
endmodule

bind cipv_top cipv_top_checker cipv_top_checker_inst (.*);

// *** sim/cipv_mem_model.sv ***
// Byte memory on the core side: page zero stack and vector page.
// Assumes read data is wanted two cycles after the read strobe.
`timescale 1ns/10ps
module cipv_mem_model (
  // Clock and reset
  input  wire        i_clk,
  input  wire        i_rst_n,
  // Memory port
  input  wire        i_we,
  input  wire        i_re,
  input  wire [15:0] i_addr,
  input  wire [7:0]  i_wdata,
  output reg  [7:0]  o_rdata
);
  reg  [7:0] ram [0:255];
  // Vector page is a fixed pattern so each slot differs
  wire [7:0] rd_w = (i_addr[15:8] == 8'hFF) ? (i_addr[7:0] ^ 8'hA5)
                                            : ram[i_addr[7:0]];

  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= 8'h00;
    end else begin
      if (i_we)
        ram[i_addr[7:0]] <= i_wdata;
      // One stage: strobe launched at edge n, taken by the block at n+2
      // Undriven bus shows the inverse, not a stale copy
      o_rdata <= i_re ? rd_w : ~o_rdata;
    end
  end
endmodule

// *** sim/testbench.sv ***
// Self-checking bench for the interrupt priority and vectoring block.
// Assumes the memory model answers reads two cycles after the strobe.
`timescale 1ns/10ps
module testbench;
  reg         I_CLK_SYS, I_RST_N, i_instr_done, i_software_irq_instr;
  reg         i_return_from_irq_instr, i_break_hit, i_ccr_load;
  reg         i_ext_request_pin, i_ext_request_mask, i_ext_request_ack;
  reg         i_pll_lock, i_pll_change_enable, i_pll_change_ack;
  reg         i_spi_rx_xfer, i_spi_rx_read, i_spi_rx_enable, i_spi_tx_xfer;
  reg         i_spi_tx_ack, i_spi_tx_enable, i_spi_master, i_spi_busy;
  reg         i_spi_ss, i_spi_mode_fault_detect_en, i_spi_error_enable;
  reg         i_spi_error_ack, i_keypad_req, i_converter_req, i_timebase_req;
  reg  [15:0] i_next_pc, seed, pcs, v;
  reg  [7:0]  i_index_low, i_accum, i_ccr;
  reg  [1:0]  i_tmr_count_zero, i_tmr_modulo_match;
  reg  [1:0]  i_timer_overflow_enable, i_timer_overflow_ack;
  reg  [3:0]  i_tmr_chan_event, i_timer_channel_enable, i_timer_channel_ack;
  reg  [2:0]  i_sci_req;
  wire [7:0]  i_mem_rdata, o_ccr, o_index_low, o_accum, o_mem_wdata;
  wire        o_busy, o_pc_load, o_ctx_restore, o_mem_we, o_mem_re;
  wire        o_ext_request_flag, o_pll_change_flag, o_spi_rx_full_flag;
  wire        o_spi_tx_empty_flag, o_spi_mode_fault_flag, o_spi_overflow_flag;
  wire [15:0] o_pc, o_mem_addr;
  wire [16:1] o_pending_indicator_n;
  wire [1:0]  o_timer_overflow_flag;
  wire [3:0]  o_timer_channel_flag;
  reg  [15:0] wa [0:7];
  reg  [7:0]  wd [0:7];
  reg  [7:0]  ex [0:4];
  integer     num_errors = 0, compares = 0, cyc = 0, nw = 0, k, j, p, q;

  cipv_top cipv_top_inst (.*);
  cipv_mem_model cipv_mem_model_inst (.i_clk(I_CLK_SYS), .i_rst_n(I_RST_N),
    .i_we(o_mem_we), .i_re(o_mem_re), .i_addr(o_mem_addr),
    .i_wdata(o_mem_wdata), .o_rdata(i_mem_rdata));

  initial begin
    I_CLK_SYS = 1'h0;
    forever #4 I_CLK_SYS = ~I_CLK_SYS;
  end

  function [15:0] nxt(input [15:0] s);
    nxt = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  function [7:0] rom(input [15:0] a);
    rom = a[7:0] ^ 8'hA5;
  endfunction

  task chk(input [15:0] got, input [15:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask

  task results;
    begin
      $display("errors=%0d compares=%0d", num_errors, compares);
      if (num_errors == 0 && compares > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask

  always @(posedge I_CLK_SYS) begin
    cyc = cyc + 1;
    if (cyc == 8000) begin
      num_errors = num_errors + 1;
      results;
    end
    if (o_mem_we === 1'h1 && nw < 8) begin
      wa[nw] = o_mem_addr;
      wd[nw] = o_mem_wdata;
      nw = nw + 1;
    end
  end

  task en(input e);
    begin
      {i_pll_change_enable, i_spi_rx_enable, i_spi_tx_enable,
       i_spi_error_enable, i_timer_overflow_enable,
       i_timer_channel_enable} = {10{e}};
    end
  endtask

  // Releases level sources and acknowledges every flag
  task clr;
    begin
      {i_ext_request_pin, i_sci_req, i_keypad_req, i_converter_req,
       i_timebase_req} = 7'h40;
      {i_ext_request_ack, i_pll_change_ack, i_timer_overflow_ack,
       i_timer_channel_ack, i_spi_rx_read, i_spi_tx_ack,
       i_spi_error_ack} = 11'h7FF;
      @(negedge I_CLK_SYS);
      {i_ext_request_ack, i_pll_change_ack, i_timer_overflow_ack,
       i_timer_channel_ack, i_spi_rx_read, i_spi_tx_ack,
       i_spi_error_ack} = 11'h000;
      @(negedge I_CLK_SYS);
    end
  endtask

  // Raises the source of priority s
  task trig(input integer s);
    begin
      case (s)
        1: i_ext_request_pin = 1'h0;
        2: i_pll_lock = ~i_pll_lock;
        3, 4: i_tmr_chan_event[s-3] = 1'h1;
        6, 7: i_tmr_chan_event[s-4] = 1'h1;
        5, 8: i_tmr_modulo_match[s/8] = 1'h1;
        9: i_spi_rx_xfer = 1'h1;
        10: i_spi_tx_xfer = 1'h1;
        11, 12, 13: i_sci_req[s-11] = 1'h1;
        14: i_keypad_req = 1'h1;
        15: i_converter_req = 1'h1;
        default: i_timebase_req = 1'h1;
      endcase
      @(negedge I_CLK_SYS);
      i_tmr_count_zero = i_tmr_modulo_match;
      {i_tmr_chan_event, i_tmr_modulo_match, i_spi_rx_xfer,
       i_spi_tx_xfer} = 8'h00;
      @(negedge I_CLK_SYS);
      i_tmr_count_zero = 2'h0;
      @(negedge I_CLK_SYS);
    end
  endtask

  // Waits for pc load (0), restore (1) or idle (2), bounded
  task wt(input integer w);
    begin
      k = 0;
      while (k < 40 && ((w == 0 && o_pc_load !== 1'h1) ||
             (w == 1 && o_ctx_restore !== 1'h1) ||
             (w == 2 && o_busy !== 1'h0))) begin
        @(negedge I_CLK_SYS);
        k = k + 1;
      end
    end
  endtask

  task pulse_done(input software_irq_instr, input brk);
    begin
      {i_instr_done, i_software_irq_instr, i_break_hit} = {1'h1, software_irq_instr, brk};
      @(negedge I_CLK_SYS);
      {i_instr_done, i_software_irq_instr, i_break_hit} = 3'h0;
    end
  endtask

  // Boundary with nothing allowed through
  task refuse;
    begin
      pulse_done(1'h0, 1'h0);
      @(negedge I_CLK_SYS);
      chk(o_busy, 1'h0);
    end
  endtask

  // Entry for priority s (0 is software), then return
  task take(input integer s, input m, input b);
    begin
      seed = nxt(seed);
      i_ccr = {seed[7:4], m, seed[2:0]};
      i_ccr_load = 1'h1;
      @(negedge I_CLK_SYS);
      i_ccr_load = 1'h0;
      seed = nxt(seed);
      i_next_pc = seed;
      seed = nxt(seed);
      {i_index_low, i_accum} = seed;
      pcs = i_next_pc - ((s > 0) ? 16'h0001 : 16'h0000);
      {ex[0], ex[1], ex[2], ex[3], ex[4]} =
        {pcs[7:0], pcs[15:8], i_index_low, i_accum, i_ccr};
      nw = 0;
      pulse_done(s == 0 && !b, b);
      wt(0);
      v = (s == 0) ? 16'hFFFC : 16'hFFFA - 2 * (s - 1);
      chk(o_pc, {rom(v), rom(v + 16'h0001)});
      chk(o_ccr[3], 1'h1);
      for (j = 0; j < 5; j = j + 1) begin
        chk(wa[j], 16'h00FF - j);
        chk(wd[j], ex[j]);
      end
      wt(2);
      chk(nw, 5);
      i_return_from_irq_instr = 1'h1;
      @(negedge I_CLK_SYS);
      i_return_from_irq_instr = 1'h0;
      wt(1);
      chk(o_pc, pcs);
      chk({o_index_low, o_accum}, {ex[2], ex[3]});
      chk(o_ccr, i_ccr);
      wt(2);
    end
  endtask

  initial begin
    {i_instr_done, i_software_irq_instr, i_return_from_irq_instr,
     i_break_hit, i_ccr_load, i_ext_request_mask, i_pll_lock, i_spi_rx_xfer,
     i_spi_tx_xfer, i_spi_master, i_spi_busy, i_spi_mode_fault_detect_en,
     i_tmr_count_zero, i_tmr_modulo_match, i_tmr_chan_event, i_next_pc,
     i_index_low, i_accum, i_ccr} = 60'h0;
    I_RST_N = 1'h0;
    i_spi_ss = 1'h1;
    seed = 16'h8F16;
    en(1'h1);
    clr;
    @(negedge I_CLK_SYS);
    I_RST_N = 1'h1;
    chk(o_ccr, 8'h08);
    trig(1);
    chk(o_ext_request_flag, 1'h1);
    refuse;
    clr;
    take(0, 1'h1, 1'h0);
    take(0, 1'h0, 1'h1);
    // Enables low: flags set but nothing requests
    en(1'h0);
    for (q = 2; q < 11; q = q + 1)
      trig(q);
    refuse;
    chk(o_pending_indicator_n, 16'h0000);
    clr;
    en(1'h1);
    i_ext_request_mask = 1'h1;
    trig(1);
    refuse;
    clr;
    i_ext_request_mask = 1'h0;
    // Slots 1 to 15 each against a random lower-priority competitor; slot 16 alone
    for (p = 1; p < 17; p = p + 1) begin
      seed = nxt(seed);
      if (p < 16)
        trig(p + 1 + seed % (16 - p));
      trig(p);
      chk(o_pending_indicator_n[p], 1'h1);
      take(p, 1'h0, 1'h0);
      clr;
    end
    trig(9);
    trig(9);
    chk(o_spi_overflow_flag, 1'h1);
    {i_spi_mode_fault_detect_en, i_spi_master, i_spi_ss} = 3'h6;
    @(negedge I_CLK_SYS);
    i_spi_ss = 1'h1;
    @(negedge I_CLK_SYS);
    chk(o_spi_mode_fault_flag, 1'h1);
    clr;
    // Slave case: select rising while a transfer is under way
    {i_spi_master, i_spi_busy, i_spi_ss} = 3'h2;
    @(negedge I_CLK_SYS);
    chk(o_spi_mode_fault_flag, 1'h0);
    i_spi_ss = 1'h1;
    @(negedge I_CLK_SYS);
    chk(o_spi_mode_fault_flag, 1'h1);
    clr;
    results;
  end
endmodule
